// ---- src/mdsfa_defs.vh ----
// Purpose: Shared constants of the driver state and fault arbiter
// Assumes: 10 MHz mclk
// Notes: Times in ns, cycle counts derived from the clock period
`ifndef MDSFA_DEFS_VH
`define MDSFA_DEFS_VH
`define MDSFA_CLK_NS 100
// Converter ramp timeout, ns
`define MDSFA_CONV_TMO_NS 2000000
`define MDSFA_CONV_TMO_CYC (`MDSFA_CONV_TMO_NS / `MDSFA_CLK_NS)
// Logic rail start delay and soft start, ns
`define MDSFA_RAIL_DLY_NS 100000
`define MDSFA_RAIL_DLY_CYC (`MDSFA_RAIL_DLY_NS / `MDSFA_CLK_NS)
// Functional states
`define MDSFA_ST_OFF 4'h0
`define MDSFA_ST_SUPPLY 4'h1
`define MDSFA_ST_CFG 4'h2
`define MDSFA_ST_CONV 4'h3
`define MDSFA_ST_SENSE 4'h4
`define MDSFA_ST_RAIL 4'h5
`define MDSFA_ST_STBY 4'h6
`define MDSFA_ST_PUMP 4'h7
`define MDSFA_ST_ACTIVE 4'h8
`define MDSFA_ST_RFAIL 4'h9
`define MDSFA_ST_STOP 4'ha
// Section sizes
`define MDSFA_NSUP 5
`define MDSFA_NOTH 8
`endif

// ---- src/mdsfa_prio_sec.v ----
// Purpose: One fault arbitration section with priority and hold
// Assumes: Bit 0 is the highest priority request
// Notes: Holds the serviced fault until it is released
`timescale 1ns/1ps
`default_nettype none
module mdsfa_prio_sec #(
    parameter N = 8,
    parameter FIRST_COME = 1
) (
    input wire mclk, // Clock
    input wire rst, // Async reset, active high
    input wire [N-1:0] req, // Fault condition levels
    output reg [N-1:0] grant_reg // One-hot serviced fault
);
    reg [N-1:0] pick;
    integer i;
    // Lowest index wins a tie
    always @* begin
        pick = {N{1'b0}};
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (req[i]) begin
                pick = {N{1'b0}};
                pick[i] = 1'b1;
            end
        end
    end
    // Hold serviced fault until its condition goes away
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            grant_reg <= {N{1'b0}};
        end else if (|(grant_reg & req)) begin
            if (FIRST_COME == 0) begin
                grant_reg <= pick;
            end
        end else begin
            grant_reg <= pick;
        end
    end
endmodule
`default_nettype wire

// ---- src/mdsfa_ocp_latch.v ----
// Purpose: Latched leg overcurrent flag with clearability tracking
// Assumes: pwm_period_end marks each PWM period end
// Notes: Clear only honoured once clearable
`timescale 1ns/1ps
`default_nettype none
module mdsfa_ocp_latch (
    input wire mclk, // Clock
    input wire rst, // Async reset
    input wire ocp_event, // Overcurrent event level
    input wire count_mode, // 1 counting mode, 0 immediate
    input wire pwm_period_end, // Pulse at PWM period end
    input wire in_standby, // Standby entered
    input wire clear_latched_bit, // Clear latched pulse
    output reg latched_reg // Latched fault flag
);
    reg quiet_reg;
    reg clearable;
    // Track a PWM period end since the last event
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            quiet_reg <= 1'b1;
        end else if (ocp_event) begin
            quiet_reg <= 1'b0;
        end else if (pwm_period_end) begin
            quiet_reg <= 1'b1;
        end
    end
    // Clearable condition per mode
    always @* begin
        if (count_mode) begin
            clearable = (quiet_reg & ~ocp_event) | in_standby;
        end else begin
            clearable = ~ocp_event;
        end
    end
    // Set wins over clear
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            latched_reg <= 1'b0;
        end else if (ocp_event) begin
            latched_reg <= 1'b1;
        end else if (clear_latched_bit && clearable) begin
            latched_reg <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- src/mdsfa_top.v ----
// Purpose: Functional state machine and fault arbiter of a gate driver
// Assumes: All inputs synchronous to mclk; analog checks arrive as levels
// Notes: Clear bits are one-cycle pulses from the serial port logic
// Overview of operation
// - Converter waits for supply and enable both
// - No PWM to gates before driver enable
// - Low-side pump first, high-side after
// - PWM path only after both pump lockouts
// - Reset lands in powered-down state
// - Check supply, read config, fault stops
// - Converter ramp timeout shuts down, stops
// - Optional sense; gain source select bit
// - Rail ramp with delay, then await enable
// - Pump ramp enables pumps, then operate
// - Enable falling in operation returns standby
// - Rail failure halts until supply toggle
// - Stop refuses serial until enable toggle
// - Pick highest priority; other section holds until condition ends
// - Two sections, lowest index wins
// - Other faults: first come, ties by priority
// - Section actions ORed onto fault pin
// - Non-latched: status held, action ends
// - Status clears only on clear writes
// - Latched leg overcurrent clear conditions
// - Pump lockout faults pull gates down once granted
// - Rail over-volt/current only reported
`timescale 1ns/1ps
`default_nettype none
`include "mdsfa_defs.vh"
module mdsfa_top #(
    parameter CONV_TMO = `MDSFA_CONV_TMO_CYC,
    parameter RAIL_DLY = `MDSFA_RAIL_DLY_CYC
) (
    input wire mclk, // Clock 10 MHz
    input wire rst, // Async reset, active high
    input wire supply_uvlo_ok, // Main supply lockout released
    input wire supply_enable_pin, // Supply enable above threshold
    input wire cfg_read_done, // Configuration fetch done
    input wire cfg_read_fault, // Configuration fetch fault
    input wire converter_ok, // Converter output at target
    input wire sense_enable, // Sense pin sampling enabled
    input wire gain_source_select, // 0 gain register, 1 analog pins
    input wire [3:0] gain_reg_value, // Gain from register
    input wire [3:0] gain_pin_value, // Gain sensed from pins
    input wire logic_rail_ok, // Logic rail at target
    input wire logic_rail_ovlo, // Logic rail overvoltage
    input wire logic_rail_ocp, // Logic rail overcurrent
    input wire [4:0] supply_fault_in, // Supply fault conditions B0..B4
    input wire [7:0] other_fault_in, // Other fault conditions F0..F7
    input wire driver_enable_pin, // Driver enable
    input wire low_side_pump_ok, // Low-side pump above lockout
    input wire high_side_pump_ok, // High-side pump above lockout
    input wire [5:0] pwm_in, // PWM inputs
    input wire leg_ocp_latch_en, // Leg overcurrent latched mode
    input wire leg_ocp_count_mode, // Leg overcurrent counting mode
    input wire pwm_period_end, // PWM period end pulse
    input wire clear_faults_bit, // Clear faults pulse
    input wire clear_latched_bit, // Clear latched pulse
    output reg [3:0] state_reg, // Functional state
    output reg converter_en_reg, // Converter switching enable
    output reg logic_rail_en_reg, // Logic rail regulator enable
    output reg low_pump_en_reg, // Low-side pump enable
    output reg high_pump_en_reg, // High-side pump enable
    output reg [5:0] gate_out_reg, // Gate drive, high then low sides
    output reg gate_pulldown_reg, // Slewed gate pull-down active
    output reg [3:0] amp_gain_reg, // Sense amplifier gain
    output reg serial_ok_reg, // Serial access allowed
    output reg [4:0] supply_fault_status_reg, // Supply status
    output reg [7:0] functional_fault_status_reg, // Functional status
    output reg leg_ocp_latched_reg, // Latched leg fault copy
    output wire fault_out_n // Fault pin, active low
);
    reg [3:0] state_next;
    reg [31:0] cnt_reg;
    reg driver_enable_pin_d_reg;
    reg supply_en_d_reg;
    reg sense_done_reg;
    wire [4:0] sup_req;
    wire [7:0] oth_req;
    wire [4:0] sup_grant;
    wire [7:0] oth_grant;
    wire leg_latched;
    wire active;
    wire stby;
    wire drv_rise;
    wire drv_fall;
    wire sup_toggle;
    localparam [31:0] CONV_TMO_W = CONV_TMO;
    localparam [31:0] RAIL_DLY_W = RAIL_DLY;

    assign active = (state_reg == `MDSFA_ST_ACTIVE);
    assign stby = (state_reg == `MDSFA_ST_STBY) || (state_reg == `MDSFA_ST_PUMP);
    assign drv_rise = driver_enable_pin & ~driver_enable_pin_d_reg;
    assign drv_fall = ~driver_enable_pin & driver_enable_pin_d_reg;
    assign sup_toggle = supply_enable_pin & ~supply_en_d_reg;

    // Fault requests qualified by state; F1/F2 share pump lockouts
    assign sup_req = {supply_fault_in[4],
                      supply_fault_in[3] | (logic_rail_ocp & (stby | active)),
                      supply_fault_in[2],
                      supply_fault_in[1] | (logic_rail_ovlo & (stby | active)),
                      supply_fault_in[0]};
    assign oth_req = {other_fault_in[7:5],
                      other_fault_in[4] | leg_latched,
                      other_fault_in[3],
                      other_fault_in[2:1] | {2{active & ~high_side_pump_ok}}
                          | {2{active & ~low_side_pump_ok}},
                      other_fault_in[0]};

    // Supply section: pure priority, re-evaluated each cycle
    mdsfa_prio_sec #(.N(`MDSFA_NSUP), .FIRST_COME(0)) u_sup (
        .mclk(mclk),
        .rst(rst),
        .req(sup_req),
        .grant_reg(sup_grant)
    );
    // Other section: first come holds, ties by priority
    mdsfa_prio_sec #(.N(`MDSFA_NOTH), .FIRST_COME(1)) u_oth (
        .mclk(mclk),
        .rst(rst),
        .req(oth_req),
        .grant_reg(oth_grant)
    );
    // Latched leg overcurrent
    mdsfa_ocp_latch u_ocp (
        .mclk(mclk),
        .rst(rst),
        .ocp_event(other_fault_in[4] & leg_ocp_latch_en & active),
        .count_mode(leg_ocp_count_mode),
        .pwm_period_end(pwm_period_end),
        .in_standby(stby),
        .clear_latched_bit(clear_latched_bit),
        .latched_reg(leg_latched)
    );

    // Fault pin from both sections; grants end with condition
    assign fault_out_n = ~(|sup_grant | |oth_grant);

    // Next state
    always @* begin
        state_next = state_reg;
        case (state_reg)
            `MDSFA_ST_OFF: begin
                if (supply_uvlo_ok && supply_enable_pin) begin
                    state_next = `MDSFA_ST_SUPPLY;
                end
            end
            `MDSFA_ST_SUPPLY: begin
                if (!supply_enable_pin) begin
                    state_next = `MDSFA_ST_OFF;
                end else if (supply_uvlo_ok) begin
                    state_next = `MDSFA_ST_CFG;
                end
            end
            `MDSFA_ST_CFG: begin
                if (cfg_read_fault) begin
                    state_next = `MDSFA_ST_STOP;
                end else if (cfg_read_done) begin
                    state_next = `MDSFA_ST_CONV;
                end
            end
            `MDSFA_ST_CONV: begin
                if (converter_ok) begin
                    state_next = `MDSFA_ST_SENSE;
                end else if (cnt_reg >= CONV_TMO_W - 32'h1) begin
                    state_next = `MDSFA_ST_STOP;
                end
            end
            `MDSFA_ST_SENSE: begin
                if (!sense_enable || sense_done_reg) begin
                    state_next = `MDSFA_ST_RAIL;
                end
            end
            `MDSFA_ST_RAIL: begin
                if (cnt_reg >= RAIL_DLY_W - 32'h1 && logic_rail_ok) begin
                    state_next = `MDSFA_ST_STBY;
                end else if (cnt_reg >= CONV_TMO_W - 32'h1) begin
                    state_next = `MDSFA_ST_STOP;
                end
            end
            `MDSFA_ST_STBY: begin
                if (!logic_rail_ok) begin
                    state_next = `MDSFA_ST_RFAIL;
                end else if (driver_enable_pin) begin
                    state_next = `MDSFA_ST_PUMP;
                end
            end
            `MDSFA_ST_PUMP: begin
                if (!logic_rail_ok) begin
                    state_next = `MDSFA_ST_RFAIL;
                end else if (!driver_enable_pin) begin
                    state_next = `MDSFA_ST_STBY;
                end else if (low_side_pump_ok && high_side_pump_ok) begin
                    state_next = `MDSFA_ST_ACTIVE;
                end
            end
            `MDSFA_ST_ACTIVE: begin
                if (!logic_rail_ok) begin
                    state_next = `MDSFA_ST_RFAIL;
                end else if (!driver_enable_pin) begin
                    state_next = `MDSFA_ST_STBY;
                end
            end
            `MDSFA_ST_RFAIL: begin
                if (sup_toggle) begin
                    state_next = `MDSFA_ST_OFF;
                end
            end
            `MDSFA_ST_STOP: begin
                if (drv_rise || sup_toggle) begin
                    state_next = `MDSFA_ST_OFF;
                end
            end
            default: begin
                state_next = `MDSFA_ST_OFF;
            end
        endcase
    end

    // State, timer and edge registers
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= `MDSFA_ST_OFF;
            cnt_reg <= 32'h0;
            driver_enable_pin_d_reg <= 1'b0;
            supply_en_d_reg <= 1'b0;
            sense_done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            driver_enable_pin_d_reg <= driver_enable_pin;
            supply_en_d_reg <= supply_enable_pin;
            sense_done_reg <= (state_reg == `MDSFA_ST_SENSE);
            if (state_next != state_reg) begin
                cnt_reg <= 32'h0;
            end else begin
                cnt_reg <= cnt_reg + 32'h1;
            end
        end
    end

    // Block outputs per state
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            converter_en_reg <= 1'b0;
            logic_rail_en_reg <= 1'b0;
            low_pump_en_reg <= 1'b0;
            high_pump_en_reg <= 1'b0;
            gate_out_reg <= 6'h00;
            gate_pulldown_reg <= 1'b0;
            amp_gain_reg <= 4'h0;
            serial_ok_reg <= 1'b0;
        end else begin
            // Converter runs from ramp onward, also after rail failure
            converter_en_reg <= (state_next >= `MDSFA_ST_CONV)
                && (state_next != `MDSFA_ST_STOP);
            logic_rail_en_reg <= (state_next >= `MDSFA_ST_RAIL)
                && (state_next <= `MDSFA_ST_ACTIVE);
            // Low-side first; high-side once low-side is built
            low_pump_en_reg <= (state_next == `MDSFA_ST_PUMP)
                || (state_next == `MDSFA_ST_ACTIVE);
            high_pump_en_reg <= ((state_next == `MDSFA_ST_PUMP) && low_side_pump_ok)
                || (state_next == `MDSFA_ST_ACTIVE);
            // PWM path gated by state, enable and granted pump faults
            gate_pulldown_reg <= |oth_grant[2:1];
            if (state_next == `MDSFA_ST_ACTIVE && driver_enable_pin && !(|oth_grant[2:1])) begin
                gate_out_reg <= pwm_in;
            end else begin
                gate_out_reg <= 6'h00;
            end
            if (state_reg == `MDSFA_ST_SENSE) begin
                amp_gain_reg <= gain_source_select ? gain_pin_value : gain_reg_value;
            end
            serial_ok_reg <= (state_next >= `MDSFA_ST_STBY)
                && (state_next != `MDSFA_ST_STOP);
        end
    end

    // Sticky status, set wins over clear
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            supply_fault_status_reg <= 5'h00;
            functional_fault_status_reg <= 8'h00;
            leg_ocp_latched_reg <= 1'b0;
        end else begin
            supply_fault_status_reg <= sup_req
                | (clear_faults_bit ? 5'h00 : supply_fault_status_reg);
            functional_fault_status_reg <= oth_req
                | (clear_faults_bit ? 8'h00 : functional_fault_status_reg);
            leg_ocp_latched_reg <= leg_latched;
        end
    end
endmodule
`default_nettype wire

// ---- tb/mdsfa_plant_model.sv ----
// Purpose: Converter, logic rail and charge pump response seen by the arbiter
// Assumes: Each rail ramps while its enable is held
// Notes: Slow mode stretches every ramp; kill bits force a rail low
`timescale 1ns/1ps
`default_nettype none
module mdsfa_plant_model (
    input wire logic mclk, // Clock
    input wire logic rst, // Async reset, active high
    input wire logic slow, // Slow ramps when high
    input wire logic [2:0] kill, // Force converter, rail, pumps low
    input wire logic conv_en, // Converter enable
    input wire logic rail_en, // Logic rail enable
    input wire logic lo_en, // Low-side pump enable
    input wire logic hi_en, // High-side pump enable
    output wire logic converter_ok, // Converter at target
    output wire logic logic_rail_ok, // Logic rail at target
    output wire logic low_side_pump_ok, // Low-side pump above lockout
    output wire logic high_side_pump_ok // High-side pump above lockout
);
    reg [3:0] age_reg [0:3];
    wire [3:0] en_w;
    wire [3:0] lim_w;
    integer i;
    assign en_w = {hi_en, lo_en, rail_en, conv_en};
    assign lim_w = slow ? 4'h8 : 4'h2;
    // Count enabled cycles of each rail, saturating
    always @(posedge mclk or posedge rst) begin
        for (i = 0; i < 4; i = i + 1) begin
            if (rst || !en_w[i])
                age_reg[i] <= 4'h0;
            else if (age_reg[i] != 4'hf)
                age_reg[i] <= age_reg[i] + 4'h1;
        end
    end
    // A rail reports ok once ramped, unless forced down
    assign converter_ok = (age_reg[0] >= lim_w) && !kill[0];
    assign logic_rail_ok = (age_reg[1] >= lim_w) && !kill[1];
    assign low_side_pump_ok = (age_reg[2] >= lim_w) && !kill[2];
    assign high_side_pump_ok = (age_reg[3] >= lim_w) && !kill[2];
endmodule
`default_nettype wire

// ---- tb/mdsfa_chk_sva.sv ----
// Purpose: Concurrent checks on the state machine and gate path ports
// Assumes: One clock domain, async active-high reset
// Notes: Bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module mdsfa_chk #(
    parameter CONV_TMO = 20000
) (
    input wire logic mclk, // Clock
    input wire logic rst, // Async reset
    input wire logic supply_uvlo_ok, // Supply lockout released
    input wire logic supply_enable_pin, // Supply enable
    input wire logic cfg_read_done, // Config fetch done
    input wire logic cfg_read_fault, // Config fetch fault
    input wire logic logic_rail_ok, // Logic rail ok
    input wire logic driver_enable_pin, // Driver enable
    input wire logic low_side_pump_ok, // Low-side pump ok
    input wire logic high_side_pump_ok, // High-side pump ok
    input wire logic clear_faults_bit, // Clear faults pulse
    input wire logic clear_latched_bit, // Clear latched pulse
    input wire logic [3:0] state_reg, // Functional state
    input wire logic converter_en_reg, // Converter enable
    input wire logic low_pump_en_reg, // Low-side pump enable
    input wire logic high_pump_en_reg, // High-side pump enable
    input wire logic [5:0] gate_out_reg, // Gate drive
    input wire logic [7:0] functional_fault_status_reg // Functional status
);
    reg [31:0] conv_cnt_reg;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Cycles spent waiting on the converter output
    always @(posedge mclk or posedge rst) begin
        if (rst)
            conv_cnt_reg <= 32'h0;
        else
            conv_cnt_reg <= (state_reg == 4'h3) ? conv_cnt_reg + 32'h1 : 32'h0;
    end
    property p_conv_wait; (state_reg == 4'h0 && !(supply_uvlo_ok && supply_enable_pin))
        |=> state_reg == 4'h0; endproperty
    a_conv_wait: assert property (p_conv_wait) else $error("start before supply");
    property p_gate_block; !driver_enable_pin |=> gate_out_reg == 6'h00; endproperty
    a_gate_block: assert property (p_gate_block) else $error("gates without enable");
    property p_pump_order; $rose(high_pump_en_reg) |-> low_pump_en_reg && $past(low_side_pump_ok);
    endproperty
    a_pump_order: assert property (p_pump_order) else $error("pump order");
    property p_pwm_path; (state_reg != 4'h8 && !(low_side_pump_ok && high_side_pump_ok))
        |=> gate_out_reg == 6'h00; endproperty
    a_pwm_path: assert property (p_pwm_path) else $error("gates before pumps");
    property p_cfg_fault; (state_reg == 4'h2 && cfg_read_done && cfg_read_fault)
        |=> state_reg == 4'ha; endproperty
    a_cfg_fault: assert property (p_cfg_fault) else $error("config fault not stopped");
    property p_conv_tmo; conv_cnt_reg <= CONV_TMO + 2; endproperty
    a_conv_tmo: assert property (p_conv_tmo) else $error("converter wait too long");
    property p_drop_en; (state_reg == 4'h8 && !driver_enable_pin && logic_rail_ok)
        |=> state_reg == 4'h6 && !low_pump_en_reg && !high_pump_en_reg; endproperty
    a_drop_en: assert property (p_drop_en) else $error("enable drop ignored");
    property p_rail_fail; (state_reg == 4'h8 && !logic_rail_ok)
        |=> state_reg == 4'h9 && converter_en_reg; endproperty
    a_rail_fail: assert property (p_rail_fail) else $error("rail fail missed");
    property p_sticky; (!clear_faults_bit && !clear_latched_bit) |=> (functional_fault_status_reg
        & $past(functional_fault_status_reg)) == $past(functional_fault_status_reg); endproperty
    a_sticky: assert property (p_sticky) else $error("status lost without clear");
endmodule
bind mdsfa_top mdsfa_chk #(.CONV_TMO(CONV_TMO)) i_mdsfa_chk (.*);
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the driver state and fault arbiter
// Assumes: Plant model answers rail and pump enables
// Notes: Short converter and rail counts keep the run brief
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam TMO = 20;
    reg mclk = 1'b0, rst = 1'b1, uvlo = 1'b0, supen = 1'b0, cfg_done = 1'b1, cfg_flt = 1'b1;
    reg sense_en = 1'b1, gsel = 1'b0, ovlo = 1'b0, ocp = 1'b0, den = 1'b0, slow = 1'b0;
    reg latch_en = 1'b0, cnt_mode = 1'b0, ppe = 1'b0, clr_f = 1'b0, clr_l = 1'b0;
    reg [3:0] greg = 4'h3, gpin = 4'hc;
    reg [7:0] oth_f = 8'h00;
    reg [4:0] sup_f = 5'h00;
    reg [5:0] pwm = 6'h2d;
    reg [2:0] kill = 3'h0;
    wire conv_ok, rail_ok, lo_ok, hi_ok, conv_en, rail_en, lo_en, hi_en, pd, ser_ok, leg_l, fault_n;
    wire [3:0] st, gain;
    wire [5:0] gate;
    wire [4:0] sup_st;
    wire [7:0] fun_st;
    integer fail_count = 0, compares = 0, k;
    // Clock of 100 ns period
    always #50 mclk = ~mclk;
    mdsfa_top #(.CONV_TMO(TMO), .RAIL_DLY(5)) i_mdsfa_top (.mclk(mclk), .rst(rst),
        .supply_uvlo_ok(uvlo), .supply_enable_pin(supen), .cfg_read_done(cfg_done),
        .cfg_read_fault(cfg_flt), .converter_ok(conv_ok), .sense_enable(sense_en),
        .gain_source_select(gsel), .gain_reg_value(greg), .gain_pin_value(gpin),
        .logic_rail_ok(rail_ok), .logic_rail_ovlo(ovlo), .logic_rail_ocp(ocp),
        .supply_fault_in(sup_f), .other_fault_in(oth_f), .driver_enable_pin(den),
        .low_side_pump_ok(lo_ok), .high_side_pump_ok(hi_ok), .pwm_in(pwm),
        .leg_ocp_latch_en(latch_en), .leg_ocp_count_mode(cnt_mode), .pwm_period_end(ppe),
        .clear_faults_bit(clr_f), .clear_latched_bit(clr_l), .state_reg(st),
        .converter_en_reg(conv_en), .logic_rail_en_reg(rail_en), .low_pump_en_reg(lo_en),
        .high_pump_en_reg(hi_en), .gate_out_reg(gate), .gate_pulldown_reg(pd),
        .amp_gain_reg(gain), .serial_ok_reg(ser_ok), .supply_fault_status_reg(sup_st),
        .functional_fault_status_reg(fun_st), .leg_ocp_latched_reg(leg_l), .fault_out_n(fault_n));
    mdsfa_plant_model i_mdsfa_plant_model (.mclk(mclk), .rst(rst), .slow(slow), .kill(kill),
        .conv_en(conv_en), .rail_en(rail_en), .lo_en(lo_en), .hi_en(hi_en),
        .converter_ok(conv_ok), .logic_rail_ok(rail_ok), .low_side_pump_ok(lo_ok),
        .high_side_pump_ok(hi_ok));
    // Print counts and verdict, then stop
    task wrap_up;
        begin
            $display("compares %0d mismatches %0d", compares, fail_count);
            if (fail_count == 0 && compares > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    // Compare one value against its expectation
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // Step n edges, then settle 1 ns past the edge
    task tick(input integer n);
        begin
            repeat (n) @(posedge mclk);
            #1;
        end
    endtask
    // Bounded wait for a state; a miss ends the run
    task wait_st(input [3:0] s, input integer lim);
        integer i;
        begin
            for (i = 0; i < lim && st !== s; i = i + 1)
                tick(1);
            chk(st, s);
            if (st !== s)
                wrap_up;
        end
    endtask
    // One-cycle pulse on the clear bits
    task clear(input f, input l);
        begin
            clr_f = f;
            clr_l = l;
            tick(1);
            clr_f = 1'b0;
            clr_l = 1'b0;
            tick(1);
        end
    endtask
    // Reset for 10 cycles
    task restart;
        begin
            rst = 1'b1;
            tick(10);
            rst = 1'b0;
        end
    endtask
    // Main sequence
    initial begin
        tick(10);
        chk({st, fault_n, ser_ok}, 8'h02);
        rst = 1'b0;
        uvlo = 1'b1;
        tick(6);
        chk({st, conv_en}, 8'h00);
        supen = 1'b1;
        wait_st(4'ha, 10);
        chk({conv_en, ser_ok}, 8'h00);
        cfg_flt = 1'b0;
        den = 1'b1;
        tick(1);
        chk(st == 4'ha, 8'h00);
        den = 1'b0;
        kill = 3'h1;
        restart;
        wait_st(4'ha, TMO + 20);
        chk(conv_en, 8'h00);
        for (k = 0; k < 2; k = k + 1) begin
            kill = 3'h0;
            gsel = k[0];
            slow = k[0];
            sense_en = k[0];
            restart;
            wait_st(4'h6, 80);
            chk(gain, k[0] ? gpin : greg);
            chk({rail_en, ser_ok}, 8'h03);
        end
        tick(4);
        chk({st, gate}, 16'h180);
        ovlo = 1'b1;
        tick(2);
        chk({st, fault_n}, 8'h0c);
        ovlo = 1'b0;
        tick(2);
        chk({sup_st[1], fault_n}, 8'h03);
        clear(1'b1, 1'b0);
        chk(sup_st, 8'h00);
        sup_f = 5'h11;
        tick(2);
        chk({sup_st, fault_n}, 16'h22);
        sup_f = 5'h00;
        tick(2);
        clear(1'b1, 1'b0);
        chk({sup_st, fault_n}, 16'h01);
        den = 1'b1;
        wait_st(4'h8, 40);
        chk({lo_en, hi_en}, 8'h03);
        pwm = 6'h12;
        tick(2);
        chk(gate, pwm);
        oth_f = 8'h40;
        tick(2);
        chk(fault_n, 8'h00);
        kill = 3'h4;
        tick(4);
        chk(pd, 8'h00);
        oth_f = 8'h00;
        tick(3);
        chk({pd, gate}, 8'h40);
        chk(fun_st[6], 8'h01);
        kill = 3'h0;
        tick(3);
        chk({pd, gate}, {2'b00, pwm});
        oth_f = 8'h40;
        kill = 3'h4;
        tick(3);
        chk({pd, gate}, 16'h40);
        oth_f = 8'h00;
        kill = 3'h0;
        tick(3);
        chk({pd, gate}, {2'b00, pwm});
        clear(1'b1, 1'b0);
        latch_en = 1'b1;
        oth_f = 8'h10;
        tick(2);
        clear(1'b0, 1'b1);
        chk(leg_l, 8'h01);
        oth_f = 8'h00;
        tick(2);
        clear(1'b0, 1'b1);
        chk(leg_l, 8'h00);
        cnt_mode = 1'b1;
        oth_f = 8'h10;
        tick(2);
        oth_f = 8'h00;
        tick(2);
        clear(1'b0, 1'b1);
        chk(leg_l, 8'h01);
        ppe = 1'b1;
        tick(1);
        ppe = 1'b0;
        clear(1'b0, 1'b1);
        chk(leg_l, 8'h00);
        den = 1'b0;
        wait_st(4'h6, 3);
        chk({lo_en, hi_en, gate}, 8'h00);
        den = 1'b1;
        wait_st(4'h8, 40);
        kill = 3'h2;
        wait_st(4'h9, 5);
        chk({conv_en, gate}, 8'h40);
        wrap_up;
    end
endmodule
`default_nettype wire
